// ### rtl/csc_consts.svh
// Constants of the channel sequence control block: offsets, bits, timing.
// Assumes inclusion by bare name from the package and the design files.
`ifndef CSC_CONSTS_SVH
`define CSC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses), control reset value and field bits
// ----------------------------------------------------------------------
`define CSC_OFF_CTRL 8'h00
`define CSC_OFF_STAT 8'h04
`define CSC_OFF_DATA 8'h08
`define CSC_OFF_INFO 8'h0c
`define CSC_CTRL_RST 8'h00
`define CSC_CTRL_TYPE1 0
`define CSC_CTRL_ASYNC 1
`define CSC_TX_DEV_LSB 8
`define CSC_TX_SUPP 12
`define CSC_DATA_RXV 8
`define CSC_DATA_TXV 9

// ----------------------------------------------------------------------
// Status byte bits, commands, sizes
// ----------------------------------------------------------------------
`define CSC_ST_ATTN 7
`define CSC_ST_SMOD 6
`define CSC_ST_CUE 5
`define CSC_ST_BUSY 4
`define CSC_ST_CE 3
`define CSC_ST_DE 2
`define CSC_ST_UC 1
`define CSC_ST_UE 0
`define CSC_CMD_TIO 8'h00
`define CSC_DEV_W 4
`define CSC_NDEV 16

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CSC_CLK_MHZ 125
`define CSC_SUP_NS 250
`define CSC_SUP_CYC ((`CSC_SUP_NS * `CSC_CLK_MHZ + 999) / 1000)

`endif

// ### rtl/csc_pkg.sv
// Types shared by the channel sequence control block.
// Assumes csc_consts.svh is on the include path.
`include "csc_consts.svh"

package csc_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_REQ, ST_POLL, ST_POLL_END, ST_SEL, ST_CMD,
    ST_STAT, ST_STAT_END, ST_STACK, ST_DATA, ST_DWAIT
  } csc_state_e;

  typedef struct packed {
    logic opl_out;
    logic sel_out;
    logic hold_out;
    logic addr_out;
    logic cmd_out;
    logic srv_out;
    logic dat_out;
    logic sup_out;
  } csc_tags_s;

  typedef struct packed {
    logic [`CSC_NDEV-1:0] cond;
    logic de_hold;
    logic [`CSC_DEV_W-1:0] de_dev;
    logic [5:0] low_cnt;
    logic lock;
    logic [`CSC_DEV_W-1:0] lock_dev;
  } csc_chain_s;

  typedef struct packed {
    csc_state_e st;
    logic opl_in;
    logic addr_in;
    logic stat_in;
    logic srv_in;
    logic req_in;
    logic [7:0] bus_in;
    logic [`CSC_DEV_W-1:0] dev;
    logic [7:0] cmd;
    logic [7:0] stat;
    logic from_pend;
    logic pend;
    logic [7:0] pend_stat;
    logic [`CSC_DEV_W-1:0] pend_dev;
    logic pend_supp;
    logic stacked;
    logic tx_v;
    logic [7:0] tx_byte;
    logic rx_v;
    logic [7:0] rx_byte;
    logic xfer;
    logic first;
    logic contig;
    logic chain_ind;
    logic ce_chain;
    logic sense_rej;
    logic [7:0] ctrl;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic wr_pend;
    logic [7:0] wr_addr;
  } csc_state_s;

endpackage

// ### rtl/csc_tag_sync.sv
// Two-flop synchroniser with edge detection for inbound channel lines.
// Assumes inputs are asynchronous to hclk.
`timescale 1ns/1ns

module csc_tag_sync #(
  parameter int W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  // Stage 0 feeds only stage 1; stage 2 keeps the previous level
  logic [2:0][W-1:0] sq;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sq <= '0;
    else
      sq <= {sq[1], sq[0], async_in};
  end

  assign lvl = sq[1];
  assign rise = sq[1] & ~sq[2];
  assign fall = ~sq[1] & sq[2];

endmodule

// ### rtl/csc_chain.sv
// Per-device command-chaining conditions and chaining holds.
// Assumes one-cycle event pulses from the sequence logic on hclk.
`timescale 1ns/1ns
`include "csc_consts.svh"

module csc_chain #(
  parameter int LOWC = `CSC_SUP_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic type1,
  input wire logic sup_lvl,
  input wire logic set_v,
  input wire logic clr_v,
  input wire logic clr_all,
  input wire logic de_v,
  input wire logic ce_lock_v,
  input wire logic [`CSC_DEV_W-1:0] dev,
  output logic [`CSC_NDEV-1:0] cond,
  output logic de_hold,
  output logic lock,
  output logic [`CSC_DEV_W-1:0] lock_dev
);

  csc_pkg::csc_chain_s q, n;
  logic [`CSC_DEV_W-1:0] ix;

  always_comb
  begin
    n = q;
    // A single shared condition when the unit is of the first type
    ix = type1 ? '0 : dev;
    if (q.de_hold && !sup_lvl)
      n.low_cnt = q.low_cnt + 6'h01;
    else
      n.low_cnt = 6'h00;
    if (q.de_hold && !sup_lvl && q.low_cnt >= 6'(LOWC - 1))
    begin
      n.cond[q.de_dev] = 1'b0;
      n.de_hold = 1'b0;
    end
    if (clr_all)
    begin
      n.cond = '0;
      n.de_hold = 1'b0;
      n.lock = 1'b0;
    end
    if (clr_v)
      n.cond[ix] = 1'b0;
    if (set_v)
    begin
      if (type1)
        n.cond = '0;
      n.cond[ix] = 1'b1;
      n.de_hold = 1'b0;
      n.lock = 1'b0;
    end
    if (de_v)
    begin
      n.de_hold = 1'b1;
      n.de_dev = ix;
      if (dev == q.lock_dev)
        n.lock = 1'b0;
    end
    if (ce_lock_v && type1)
    begin
      n.lock = 1'b1;
      n.lock_dev = dev;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q <= '0;
    else
      q <= n;
  end

  assign cond = q.cond;
  assign de_hold = q.de_hold;
  assign lock = q.lock;
  assign lock_dev = q.lock_dev;

endmodule

// ### rtl/csc_ctrl.sv
// Control-unit end of a byte-wide channel tag-and-bus link, with an
// AHB-Lite register port. Assumes all channel lines are asynchronous.
`timescale 1ns/1ns
`include "csc_consts.svh"

module csc_ctrl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire csc_pkg::csc_tags_s tags_out,
  input wire logic [7:0] bus_out,
  output logic opl_in,
  output logic addr_in,
  output logic stat_in,
  output logic srv_in,
  output logic req_in,
  output logic [7:0] bus_in
);

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  csc_pkg::csc_state_s q, n;
  csc_pkg::csc_tags_s lv, ri, fa;
  logic [15:0] s_lvl, s_ri, s_fa;
  logic [7:0] bo;
  logic [`CSC_NDEV-1:0] cond;
  logic de_hold, lock;
  logic [`CSC_DEV_W-1:0] lock_dev, ch_dev;
  logic set_v, clr_v, clr_all, de_v, ce_lock_v;
  logic ign_sup, sup_ok;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic is_in_cmd(input logic [7:0] c);
    is_in_cmd = c[1:0] == 2'b10 || c[3:0] == 4'h4 || c[3:0] == 4'hc;
  endfunction

  function automatic logic is_out_cmd(input logic [7:0] c);
    is_out_cmd = c[1:0] == 2'b01 || (c[1:0] == 2'b11 && c != 8'h03);
  endfunction

  // Status that ends chaining in the channel
  function automatic logic kills_chain(input logic [7:0] s);
    kills_chain = s[`CSC_ST_ATTN] || s[`CSC_ST_CUE] || s[`CSC_ST_BUSY]
      || s[`CSC_ST_UE] || (s[`CSC_ST_UC] && !s[`CSC_ST_SMOD]);
  endfunction

  function automatic logic [31:0] rd_mux(input logic [7:0] a,
    input csc_pkg::csc_state_s s, input logic [`CSC_NDEV-1:0] c,
    input logic hold, input logic lk);
    unique case (a)
      `CSC_OFF_CTRL: rd_mux = {24'h000000, s.ctrl};
      `CSC_OFF_STAT: rd_mux = {16'h0000, 3'h0, s.pend_supp, s.pend_dev,
        s.pend_stat} | {15'h0000, s.stacked, 16'h0000}
        | {14'h0000, s.pend, 17'h00000};
      `CSC_OFF_DATA: rd_mux = {22'h000000, s.tx_v, s.rx_v, s.rx_byte};
      `CSC_OFF_INFO: rd_mux = {c, s.cmd, 3'h0, s.sense_rej, lk, hold,
        s.chain_ind, s.xfer};
      default: rd_mux = 32'h00000000;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Inbound lines
  // ----------------------------------------------------------------------
  csc_tag_sync #(.W(16)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({tags_out, bus_out}),
    .lvl(s_lvl),
    .rise(s_ri),
    .fall(s_fa)
  );

  assign lv = csc_pkg::csc_tags_s'(s_lvl[15:8]);
  assign ri = csc_pkg::csc_tags_s'(s_ri[15:8]);
  assign fa = csc_pkg::csc_tags_s'(s_fa[15:8]);
  assign bo = s_lvl[7:0];

  csc_chain u_chain (
    .hclk(hclk),
    .hresetn(hresetn),
    .type1(q.ctrl[`CSC_CTRL_TYPE1]),
    .sup_lvl(lv.sup_out),
    .set_v(set_v),
    .clr_v(clr_v),
    .clr_all(clr_all),
    .de_v(de_v),
    .ce_lock_v(ce_lock_v),
    .dev(ch_dev),
    .cond(cond),
    .de_hold(de_hold),
    .lock(lock),
    .lock_dev(lock_dev)
  );

  // First byte after a reconnection is sent regardless of suppression
  assign ign_sup = q.first && !q.contig;
  assign sup_ok = !lv.sup_out || ign_sup;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    n = q;
    set_v = 1'b0;
    clr_v = 1'b0;
    clr_all = 1'b0;
    de_v = 1'b0;
    ce_lock_v = 1'b0;
    ch_dev = q.dev;
    n.hreadyout = 1'b1;
    n.hresp = 1'b0;

    // Bus writes land in the data phase; hardware events below win, except a data write beats an input byte's retirement in ST_DWAIT
    n.wr_pend = 1'b0;
    if (q.wr_pend)
    begin
      unique case (q.wr_addr)
        `CSC_OFF_CTRL: n.ctrl = hwdata[7:0];
        `CSC_OFF_STAT:
          if (!q.pend)
          begin
            n.pend = 1'b1;
            n.pend_stat = hwdata[7:0];
            n.pend_dev = hwdata[`CSC_TX_DEV_LSB +: `CSC_DEV_W];
            n.stacked = 1'b0;
            n.pend_supp = (hwdata[`CSC_TX_SUPP]
              && q.ctrl[`CSC_CTRL_ASYNC])
              || (hwdata[`CSC_ST_DE] && !q.ce_chain);
          end
        `CSC_OFF_DATA:
          begin
            n.tx_byte = hwdata[7:0];
            n.tx_v = 1'b1;
          end
        `CSC_OFF_INFO:
          if (hwdata[4])
            n.sense_rej = 1'b0;
        default: n.ctrl = q.ctrl;
      endcase
    end
    if (hsel && htrans[1] && hready)
    begin
      n.wr_pend = hwrite;
      n.wr_addr = haddr[7:0];
      if (!hwrite)
      begin
        n.hrdata = rd_mux(haddr[7:0], q, cond, de_hold, lock);
        if (haddr[7:0] == `CSC_OFF_DATA)
          n.rx_v = 1'b0;
      end
    end

    unique case (q.st)
      csc_pkg::ST_IDLE:
        if (lv.sel_out && lv.addr_out && bo[7:4] == q.ctrl[7:4])
        begin
          n.opl_in = 1'b1;
          n.addr_in = 1'b1;
          n.bus_in = bo;
          n.dev = bo[`CSC_DEV_W-1:0];
          n.contig = 1'b1;
          n.st = csc_pkg::ST_SEL;
        end
        else if (q.pend && !(q.pend_supp && lv.sup_out)
          && !(de_hold && q.pend_dev != ch_dev)
          && !(lock && q.pend_stat[`CSC_ST_DE]
          && q.pend_dev != lock_dev))
        begin
          n.req_in = 1'b1;
          n.st = csc_pkg::ST_REQ;
        end
      csc_pkg::ST_REQ:
        if (ri.sel_out && !lv.addr_out)
        begin
          n.req_in = 1'b0;
          n.opl_in = 1'b1;
          n.addr_in = 1'b1;
          n.contig = 1'b0;
          n.dev = q.pend_dev;
          n.bus_in = {q.ctrl[7:4], q.pend_dev};
          n.st = csc_pkg::ST_POLL;
        end
      csc_pkg::ST_POLL:
        if (ri.cmd_out)
        begin
          n.addr_in = 1'b0;
          n.st = csc_pkg::ST_POLL_END;
        end
      csc_pkg::ST_POLL_END:
        if (!lv.cmd_out)
        begin
          n.stat = q.pend_stat;
          n.bus_in = q.pend_stat;
          n.from_pend = 1'b1;
          n.stat_in = 1'b1;
          n.st = csc_pkg::ST_STAT;
        end
      csc_pkg::ST_SEL:
        if (ri.cmd_out)
        begin
          n.addr_in = 1'b0;
          n.cmd = bo;
          n.st = csc_pkg::ST_CMD;
        end
      csc_pkg::ST_CMD:
        if (!lv.cmd_out)
        begin
          n.stat_in = 1'b1;
          n.from_pend = 1'b0;
          n.stat = 8'h00;
          if (lv.sup_out && !cond[q.ctrl[`CSC_CTRL_TYPE1] ? '0 : q.dev])
          begin
            n.stat[`CSC_ST_UC] = 1'b1;
            n.sense_rej = 1'b1;
          end
          else if (q.cmd == `CSC_CMD_TIO && q.pend && q.pend_dev == q.dev)
          begin
            n.stat = q.pend_stat;
            n.from_pend = 1'b1;
          end
          else
          begin
            set_v = 1'b1;
            n.xfer = is_in_cmd(q.cmd) || is_out_cmd(q.cmd);
            n.first = 1'b1;
          end
          n.bus_in = n.stat;
          n.st = csc_pkg::ST_STAT;
        end
      csc_pkg::ST_STAT:
        if (ri.srv_out)
        begin
          // Chaining sampled at every acceptance; stacked status has none
          n.chain_ind = lv.sup_out && !(q.from_pend && q.stacked);
          n.stat_in = 1'b0;
          if (q.from_pend)
            n.pend = 1'b0;
          if (q.stat[`CSC_ST_CE])
            n.ce_chain = n.chain_ind;
          if (kills_chain(q.stat))
            clr_v = 1'b1;
          else if ((q.stat[`CSC_ST_CE] || q.stat[`CSC_ST_DE])
            && !n.chain_ind)
            clr_v = 1'b1;
          else if (q.stat[`CSC_ST_DE])
            de_v = 1'b1;
          else if (q.stat[`CSC_ST_CE])
            ce_lock_v = 1'b1;
          if (q.stat[`CSC_ST_CE] || q.stat[`CSC_ST_DE]
            || kills_chain(q.stat))
            n.xfer = 1'b0;
          n.st = csc_pkg::ST_STAT_END;
        end
        else if (ri.cmd_out)
        begin
          n.stat_in = 1'b0;
          clr_v = 1'b1;
          if (q.from_pend || q.stat != 8'h00 || q.cmd == `CSC_CMD_TIO)
          begin
            n.pend = 1'b1;
            n.pend_stat = q.stat;
            n.pend_dev = q.dev;
            n.stacked = 1'b1;
            n.pend_supp = 1'b1;
          end
          n.xfer = 1'b0;
          n.st = csc_pkg::ST_STACK;
        end
      csc_pkg::ST_STAT_END:
        if (!lv.srv_out)
        begin
          n.opl_in = q.xfer;
          n.st = q.xfer ? csc_pkg::ST_DATA : csc_pkg::ST_IDLE;
        end
      csc_pkg::ST_STACK:
        if (!lv.sel_out)
        begin
          n.opl_in = 1'b0;
          n.st = csc_pkg::ST_IDLE;
        end
      csc_pkg::ST_DATA:
        if (q.pend && q.pend_dev == q.dev)
        begin
          n.stat = q.pend_stat;
          n.bus_in = q.pend_stat;
          n.from_pend = 1'b1;
          n.stat_in = 1'b1;
          n.st = csc_pkg::ST_STAT;
        end
        else if (!lv.srv_out && sup_ok
          && (is_in_cmd(q.cmd) ? q.tx_v : !q.rx_v))
        begin
          n.srv_in = 1'b1;
          n.bus_in = q.tx_byte;
          n.st = csc_pkg::ST_DWAIT;
        end
      csc_pkg::ST_DWAIT:
        if (ri.srv_out)
        begin
          n.srv_in = 1'b0;
          n.first = 1'b0;
          // A byte written in this very cycle must not be lost
          if (is_in_cmd(q.cmd) && !(q.wr_pend
            && q.wr_addr == `CSC_OFF_DATA))
            n.tx_v = 1'b0;
          else
          begin
            n.rx_byte = bo;
            n.rx_v = 1'b1;
          end
          n.st = csc_pkg::ST_DATA;
        end
    endcase

    // Channel-side resets and disconnect override the sequence
    if (!lv.opl_out)
    begin
      if (lv.sup_out)
        clr_v = 1'b1;
      else
      begin
        clr_all = 1'b1;
        n.pend = 1'b0;
      end
      n.st = csc_pkg::ST_IDLE;
    end
    else if (ri.addr_out && (q.st == csc_pkg::ST_DATA
      || q.st == csc_pkg::ST_DWAIT))
    begin
      clr_v = 1'b1;
      n.st = csc_pkg::ST_IDLE;
    end
    if (n.st == csc_pkg::ST_IDLE && q.st != csc_pkg::ST_REQ
      && q.st != csc_pkg::ST_IDLE)
    begin
      n.opl_in = 1'b0;
      n.addr_in = 1'b0;
      n.stat_in = 1'b0;
      n.srv_in = 1'b0;
      n.xfer = 1'b0;
      n.bus_in = 8'h00;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
      q.st <= csc_pkg::ST_IDLE;
      q.ctrl <= `CSC_CTRL_RST;
      q.hreadyout <= 1'b1;
    end
    else
      q <= n;
  end

  assign hreadyout = q.hreadyout;
  assign hresp = q.hresp;
  assign hrdata = q.hrdata;
  assign opl_in = q.opl_in;
  assign addr_in = q.addr_in;
  assign stat_in = q.stat_in;
  assign srv_in = q.srv_in;
  assign req_in = q.req_in;
  assign bus_in = q.bus_in;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  stack_keep_a: assert property (
    q.st == csc_pkg::ST_STAT && ri.cmd_out && lv.opl_out && q.stat != 0
    |=> q.pend && q.stacked && q.pend_stat == $past(q.stat))
    else $error("stacked status not retained");
  stack_drop_a: assert property (
    q.st == csc_pkg::ST_STACK && !lv.sel_out |=> !opl_in)
    else $error("no disconnect after stack");
  stack_nochain_a: assert property (
    q.st == csc_pkg::ST_STAT && ri.srv_out && q.from_pend && q.stacked
    |=> !q.chain_ind)
    else $error("stacked status carried chaining");
  burst_sup_a: assert property (
    $rose(srv_in) && !$past(ign_sup) |-> !$past(lv.sup_out))
    else $error("service in raised while suppressed");
  read_accept_a: assert property (
    q.st == csc_pkg::ST_DWAIT && ri.srv_out && is_in_cmd(q.cmd)
    && !(q.wr_pend && q.wr_addr == `CSC_OFF_DATA)
    && lv.opl_out |=> !q.tx_v && !srv_in)
    else $error("input byte not retired");
  write_take_a: assert property (
    q.st == csc_pkg::ST_DWAIT && ri.srv_out && !is_in_cmd(q.cmd)
    && lv.opl_out |=> q.rx_v && q.rx_byte == $past(bo))
    else $error("output byte not captured");
  poll_supp_a: assert property (
    $rose(req_in) |-> !($past(q.pend_supp) && $past(lv.sup_out)))
    else $error("suppressed status requested");
  reject_uc_a: assert property (
    q.st == csc_pkg::ST_CMD && !lv.cmd_out && lv.opl_out && lv.sup_out
    && !cond[q.ctrl[`CSC_CTRL_TYPE1] ? '0 : q.dev]
    |=> stat_in && bus_in[`CSC_ST_UC] && q.sense_rej)
    else $error("rejected command lacks unit check");

endmodule

// ### sim/csc_chan_model.sv
// Behavioural channel end: drives the outbound tags and bus out.
// Assumes its tasks are called one at a time, just after a rising edge.
`timescale 1ns/1ns

module csc_chan_model (
  input wire logic hclk,
  input wire logic opl_in,
  input wire logic addr_in,
  input wire logic stat_in,
  input wire logic srv_in,
  input wire logic req_in,
  output csc_pkg::csc_tags_s tags_out,
  output logic [7:0] bus_out
);
  logic [4:0] in_v;
  logic [7:0] last_q;

  assign in_v = {opl_in, addr_in, stat_in, srv_in, req_in};

  initial
  begin
    tags_out = '0;
    tags_out.opl_out = 1'b1;
    last_q = 8'h00;
    bus_out = 8'hff;
  end

  task automatic wt(input int idx, input logic v);
    while (in_v[idx] !== v)
      @(posedge hclk);
    @(posedge hclk);
  endtask

  // Released bus shows the inverse, never a stale byte
  task automatic put(input logic [7:0] b);
    bus_out <= b;
    last_q <= b;
  endtask

  task automatic rel();
    bus_out <= ~last_q;
  endtask

  // Lead of 320 ns covers the 250 ns setup
  task automatic sup(input logic v);
    tags_out.sup_out <= v;
    repeat (40)
      @(posedge hclk);
  endtask

  task automatic sel_start(input logic [7:0] adr);
    put(adr);
    tags_out.addr_out <= 1'b1;
    tags_out.sel_out <= 1'b1;
    wt(3, 1'b1);
  endtask

  task automatic poll_start();
    wt(0, 1'b1);
    tags_out.sel_out <= 1'b1;
    wt(3, 1'b1);
  endtask

  task automatic proceed(input logic [7:0] cmd);
    tags_out.addr_out <= 1'b0;
    put(cmd);
    tags_out.cmd_out <= 1'b1;
    wt(3, 1'b0);
    tags_out.cmd_out <= 1'b0;
    rel();
    wt(2, 1'b1);
  endtask

  task automatic wait_stat();
    wt(2, 1'b1);
  endtask

  task automatic accept();
    tags_out.srv_out <= 1'b1;
    wt(2, 1'b0);
    tags_out.srv_out <= 1'b0;
  endtask

  task automatic stack();
    tags_out.cmd_out <= 1'b1;
    wt(2, 1'b0);
    tags_out.sel_out <= 1'b0;
    wt(4, 1'b0);
    tags_out.cmd_out <= 1'b0;
  endtask

  task automatic wr_byte(input logic [7:0] b);
    wt(1, 1'b1);
    put(b);
    tags_out.srv_out <= 1'b1;
    wt(1, 1'b0);
    tags_out.srv_out <= 1'b0;
    rel();
  endtask

  task automatic rd_byte();
    wt(1, 1'b1);
    tags_out.srv_out <= 1'b1;
    wt(1, 1'b0);
    tags_out.srv_out <= 1'b0;
  endtask

  task automatic fin();
    wt(4, 1'b0);
    tags_out.sel_out <= 1'b0;
    repeat (8)
      @(posedge hclk);
  endtask

  // Foreign address on the bus, so the drop cannot look like a selection
  task automatic disc(input logic [7:0] nb);
    put(nb);
    tags_out.addr_out <= 1'b1;
    wt(4, 1'b0);
    tags_out.addr_out <= 1'b0;
    tags_out.sel_out <= 1'b0;
    repeat (40)
      @(posedge hclk);
  endtask
endmodule

// ### sim/channel_sequence_controls_tb.sv
// Self-checking bench: AHB-Lite master, channel model, control unit.
// Assumes the design files and csc_chan_model are compiled first.
`timescale 1ns/1ns
`include "csc_consts.svh"

module channel_sequence_controls_tb;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic hwrite;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  csc_pkg::csc_tags_s tags_out;
  logic [7:0] bus_out;
  logic opl_in, addr_in, stat_in, srv_in, req_in;
  logic [7:0] bus_in;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int hi = 0;
  int seed;
  logic [31:0] rd;
  logic [3:0] cu;
  logic [3:0] dv;
  logic [7:0] b;

  csc_ctrl csc_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .tags_out(tags_out),
    .bus_out(bus_out), .opl_in(opl_in), .addr_in(addr_in),
    .stat_in(stat_in), .srv_in(srv_in), .req_in(req_in), .bus_in(bus_in));

  csc_chan_model m (.hclk(hclk), .opl_in(opl_in), .addr_in(addr_in),
    .stat_in(stat_in), .srv_in(srv_in), .req_in(req_in),
    .tags_out(tags_out), .bus_out(bus_out));

  initial
    hclk = 1'b0;
  always #4 hclk = ~hclk;

  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (req_in === 1'b1)
      hi <= hi + 1;
    if (cyc == 30000)
    begin
      bad_count++;
      results();
    end
  end

  function automatic logic [7:0] sel_stat(input logic ch, input logic cd);
    sel_stat = (ch && !cd) ? 8'h01 << `CSC_ST_UC : 8'h00;
  endfunction

  function automatic logic [7:0] end_stat();
    end_stat = (8'h01 << `CSC_ST_CE) | (8'h01 << `CSC_ST_DE);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic info_bit(input int i, input logic e);
    ahb(1'b0, `CSC_OFF_INFO, 32'h0);
    chk({31'h0, rd[i]}, {31'h0, e});
  endtask

  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    seed = 16;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    hsize = 3'h0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (5)
      @(posedge hclk);
    hresetn <= 1'b1;
    cu = $random(seed);
    ahb(1'b0, `CSC_OFF_CTRL, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, `CSC_OFF_CTRL, {24'h0, cu, 4'h0});
    // Random writes, each cut short by interface disconnect
    repeat (3)
    begin
      dv = $random(seed);
      b = $random(seed);
      m.sel_start({cu, dv});
      chk({24'h0, bus_in}, {24'h0, cu, dv});
      m.proceed(8'h01);
      chk({24'h0, bus_in}, {24'h0, sel_stat(1'b0, 1'b0)});
      m.accept();
      m.wr_byte(b);
      ahb(1'b0, `CSC_OFF_DATA, 32'h0);
      chk({23'h0, rd[8:0]}, {23'h0, 1'b1, b});
      info_bit(16 + dv, 1'b1);
      m.disc({~cu, dv});
      info_bit(16 + dv, 1'b0);
    end
    // Chaining shown to a device without condition: rejected
    dv = dv + 4'h1;
    m.sup(1'b1);
    m.sel_start({cu, dv});
    m.proceed(8'h01);
    chk({24'h0, bus_in}, {24'h0, sel_stat(1'b1, 1'b0)});
    m.accept();
    m.fin();
    info_bit(4, 1'b1);
    ahb(1'b1, `CSC_OFF_INFO, 32'h10);
    m.sup(1'b0);
    // Stack, hold off while suppressed, then present again
    ahb(1'b1, `CSC_OFF_STAT, {20'h0, dv, end_stat()});
    m.poll_start();
    chk({24'h0, bus_in}, {24'h0, cu, dv});
    m.proceed(8'h00);
    chk({24'h0, bus_in}, {24'h0, end_stat()});
    m.sup(1'b1);
    m.stack();
    hi = 0;
    repeat (40)
      @(posedge hclk);
    chk(hi, 0);
    ahb(1'b0, `CSC_OFF_STAT, 32'h0);
    chk({31'h0, rd[16]}, 32'h1);
    m.sup(1'b0);
    m.poll_start();
    m.proceed(8'h00);
    chk({24'h0, bus_in}, {24'h0, end_stat()});
    m.sup(1'b1);
    m.accept();
    m.fin();
    info_bit(1, 1'b0);
    m.sup(1'b0);
    // Ending status in a data phase, accepted with chaining
    m.sel_start({cu, dv});
    m.proceed(8'h01);
    m.accept();
    m.wr_byte(8'h3c);
    ahb(1'b1, `CSC_OFF_STAT, {20'h0, dv, end_stat()});
    m.wait_stat();
    chk({24'h0, bus_in}, {24'h0, end_stat()});
    m.sup(1'b1);
    m.accept();
    m.fin();
    info_bit(1, 1'b1);
    info_bit(2, 1'b1);
    info_bit(16 + dv, 1'b1);
    m.sup(1'b0);
    info_bit(2, 1'b0);
    info_bit(16 + dv, 1'b0);
    // Type-1 read: shared condition, byte retired, burst held off
    ahb(1'b1, `CSC_OFF_CTRL, {24'h0, cu, 4'h1});
    b = $random(seed);
    ahb(1'b1, `CSC_OFF_DATA, {24'h0, b});
    m.sel_start({cu, dv});
    m.proceed(8'h02);
    m.accept();
    m.rd_byte();
    chk({24'h0, bus_in}, {24'h0, b});
    ahb(1'b0, `CSC_OFF_INFO, 32'h0);
    chk({16'h0, rd[31:16]}, 32'h1);
    m.sup(1'b1);
    ahb(1'b1, `CSC_OFF_DATA, {24'h0, ~b});
    repeat (40)
      @(posedge hclk);
    chk({31'h0, srv_in}, 32'h0);
    m.sup(1'b0);
    m.rd_byte();
    chk({24'h0, bus_in}, {24'h0, ~b});
    ahb(1'b0, `CSC_OFF_DATA, 32'h0);
    chk({31'h0, rd[9]}, 32'h0);
    m.disc({~cu, dv});
    info_bit(16, 1'b0);
    results();
  end
endmodule
